// *** core/i2c_pad_cell.sv ***
// one i2c-capable pad: gpio or open-drain i2c function, pull-up enable
// assumes i2c drive request and register fields are on ref_clk_in
`timescale 1ns/1ps
module i2c_pad_cell (
	input wire logic ref_clk_in, // system clock
	input wire logic sys_rst_in, // synchronous reset, active high
	input wire logic pad_in, // pad level as seen at the pin
	input wire logic i2c_func_sel_in, // 1 selects i2c, 0 general port
	input wire logic gpio_dir_in, // 1 drives the port bit as output
	input wire logic gpio_level_in, // port output level
	input wire logic i2c_drive_low_in, // i2c core pulls the line low
	input wire logic pullup_en_in, // pull-up enable bit
	output logic pad_out, // pad output level
	output logic pad_oe_out, // pad output enable
	output logic pullup_out, // internal pull-up enable
	output logic level_out // synchronised pad level
);
	logic next_out;
	logic next_oe;

	sync_two_ff pad_sync (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.async_in(pad_in),
		.sync_out(level_out)
	);

	// i2c is open drain: only ever drives low
	assign next_out = i2c_func_sel_in ? 1'b0 : gpio_level_in;
	assign next_oe = i2c_func_sel_in ? i2c_drive_low_in : gpio_dir_in;

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			pad_out <= 1'b0;
			pad_oe_out <= 1'b0;
			pullup_out <= 1'b1;
		end
		else
		begin
			pad_out <= next_out;
			pad_oe_out <= next_oe;
			pullup_out <= pullup_en_in;
		end
	end
endmodule : i2c_pad_cell

// *** core/pin_ctrl_pkg.sv ***
// constants for the pin default and pull-up controller
// assumes one 200 MHz clock and a synchronous active-high power-on reset
package pin_ctrl_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NUM_I2C_PINS = 6;
	localparam int NUM_STROBE_PAIRS = 4;

	// register byte addresses
	localparam logic [7:0] OFS_PULLUP_THREE = 8'h00;
	localparam logic [7:0] OFS_PULLUP_FOUR = 8'h04;
	localparam logic [7:0] OFS_PIN_FUNC = 8'h08;
	localparam logic [7:0] OFS_GPIO_DIR = 8'h0c;
	localparam logic [7:0] OFS_GPIO_OUT = 8'h10;
	localparam logic [7:0] OFS_PIN_STATUS = 8'h14;

	// pull-up enables come out of reset all on
	localparam logic [31:0] PULLUP_THREE_RST = 32'hffff_ffff;
	localparam logic [31:0] PULLUP_FOUR_RST = 32'hffff_ffff;
	localparam logic [5:0] FUNC_SEL_RST = 6'h00;
	localparam logic [5:0] GPIO_DIR_RST = 6'h00;
	localparam logic [5:0] GPIO_OUT_RST = 6'h00;

	// pull-up bit positions
	localparam int BIT_I2C_B_DATA = 31;
	localparam int BIT_I2C_B_CLOCK = 30;
	localparam int BIT_I2C_A_DATA = 29;
	localparam int BIT_I2C_A_CLOCK = 28;
	localparam int BIT_VIDEO_IN_DATA1 = 0;
	localparam int BIT_SERIAL_AUDIO_CLOCK = 31;
	localparam int BIT_I2C_C_DATA = 21;
	localparam int BIT_I2C_C_CLOCK = 20;
	localparam int BIT_SERIAL_PERIPH_RX = 0;

	// i2c-capable pin index inside the pin vectors
	localparam int IDX_A_CLOCK = 0;
	localparam int IDX_A_DATA = 1;
	localparam int IDX_B_CLOCK = 2;
	localparam int IDX_B_DATA = 3;
	localparam int IDX_C_CLOCK = 4;
	localparam int IDX_C_DATA = 5;

	// pin function register fields
	localparam int FUNC_SEL_LSB = 0;
	localparam int STROBE_REL_BIT = 16;
	localparam int CS_REL_BIT = 17;

	// pin status register fields
	localparam int STAT_LEVEL_LSB = 0;
	localparam int STAT_MODE_BIT = 8;
	localparam int STAT_DEFAULT_BIT = 9;

	// edges the mode pin synchroniser needs to fill after reset release
	localparam logic [1:0] SETTLE_CYCLES = 2'd2;

	typedef enum logic [1:0] {BOOT_SETTLE, BOOT_CAPTURE, BOOT_READY} boot_state_t;
endpackage : pin_ctrl_pkg

// *** core/pin_default_pullup_ctrl.sv ***
// pin default states, boot-mode chip-select default and pull-up registers
// assumes register port on ref_clk_in; pins and mode strap are asynchronous
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
//
// Function
// - strobe drivers stay high impedance during reset and in default state.
// - while high impedance, true strobe held low, complement held high.
// - shared chip-select/address pin defaults high for mode 0, low for 1.
// - third register bits 31..28 enable i2c b/a data and clock pull-ups.
// - fourth register bits 21 and 20 enable i2c c data and clock pull-ups.
// - third register bit 0 enables video data bit 1 pull-up; one bit per pin.
// - fourth register bit 31 audio clock, bit 0 peripheral receive pull-ups.
// - i2c pins are inputs in reset, then port inputs with pull-up on.
module pin_default_pullup_ctrl
	import pin_ctrl_pkg::*;
(
	input wire logic ref_clk_in, // 200 MHz system clock
	input wire logic sys_rst_in, // power-on reset, sync, active high
	input wire logic [pin_ctrl_pkg::ADDR_W-1:0] addr_in, // register address
	input wire logic [pin_ctrl_pkg::DATA_W-1:0] wr_data_in, // write data
	input wire logic wr_en_in, // write strobe
	input wire logic rd_en_in, // read strobe
	output logic [pin_ctrl_pkg::DATA_W-1:0] rd_data_out, // read data, next cycle
	input wire logic boot_area_size_mode_in, // boot size mode strap pin
	input wire logic [pin_ctrl_pkg::NUM_I2C_PINS-1:0] i2c_pad_in, // i2c pad levels
	input wire logic [pin_ctrl_pkg::NUM_I2C_PINS-1:0] i2c_drive_low_in, // i2c pull low
	output logic [pin_ctrl_pkg::NUM_I2C_PINS-1:0] i2c_pad_out, // i2c pad levels out
	output logic [pin_ctrl_pkg::NUM_I2C_PINS-1:0] i2c_pad_oe_out, // i2c pad enables
	output logic [pin_ctrl_pkg::NUM_I2C_PINS-1:0] i2c_pullup_out, // i2c pad pull-ups
	output logic [pin_ctrl_pkg::NUM_I2C_PINS-1:0] i2c_level_out, // synced i2c levels
	output logic [pin_ctrl_pkg::DATA_W-1:0] pullup_ctrl_three_out, // pull-ups, reg 3
	output logic [pin_ctrl_pkg::DATA_W-1:0] pullup_ctrl_four_out, // pull-ups, reg 4
	input wire logic [pin_ctrl_pkg::NUM_STROBE_PAIRS-1:0] mem_strobe_oe_in, // ctrl enable
	input wire logic [pin_ctrl_pkg::NUM_STROBE_PAIRS-1:0] mem_strobe_level_in, // ctrl level
	output logic [pin_ctrl_pkg::NUM_STROBE_PAIRS-1:0] mem_strobe_true_out, // true level
	output logic [pin_ctrl_pkg::NUM_STROBE_PAIRS-1:0] mem_strobe_true_oe_out, // true enable
	output logic [pin_ctrl_pkg::NUM_STROBE_PAIRS-1:0] mem_strobe_true_hold_low_out, // keeper
	output logic [pin_ctrl_pkg::NUM_STROBE_PAIRS-1:0] mem_strobe_comp_out, // comp level
	output logic [pin_ctrl_pkg::NUM_STROBE_PAIRS-1:0] mem_strobe_comp_oe_out, // comp enable
	output logic [pin_ctrl_pkg::NUM_STROBE_PAIRS-1:0] mem_strobe_comp_hold_high_out, // keeper
	input wire logic mem_cs_addr_level_in, // memory bus level for shared pin
	output logic chip_select_addr_shared_out, // shared pin level
	output logic chip_select_addr_shared_oe_out, // shared pin enable
	output logic boot_area_size_mode_out // latched boot size mode
);
	import pin_ctrl_pkg::*;

	logic [DATA_W-1:0] pullup_ctrl_three;
	logic [DATA_W-1:0] pullup_ctrl_four;
	logic [NUM_I2C_PINS-1:0] func_sel;
	logic [NUM_I2C_PINS-1:0] gpio_dir;
	logic [NUM_I2C_PINS-1:0] gpio_out;
	logic strobe_release;
	logic cs_release;
	logic boot_mode;
	logic [1:0] settle_count;
	boot_state_t boot_state;
	boot_state_t next_boot_state;
	logic mode_sync;
	logic [NUM_I2C_PINS-1:0] i2c_pullup_en;

	// register map, all 32-bit words: 0x00 and 0x04 pull-up enables,
	// 0x08 function ([5:0] i2c select, [16] strobe release, [17] shared pin release),
	// 0x0c port direction, 0x10 port output, 0x14 status (read only)
	// unmapped and status writes are dropped silently: there is no error response
	// address decode
	wire hit_three = (addr_in == OFS_PULLUP_THREE);
	wire hit_four = (addr_in == OFS_PULLUP_FOUR);
	wire hit_func = (addr_in == OFS_PIN_FUNC);
	wire hit_dir = (addr_in == OFS_GPIO_DIR);
	wire hit_out = (addr_in == OFS_GPIO_OUT);
	wire hit_status = (addr_in == OFS_PIN_STATUS);
	wire wr_three = wr_en_in && hit_three;
	wire wr_four = wr_en_in && hit_four;
	wire wr_func = wr_en_in && hit_func;
	wire wr_dir = wr_en_in && hit_dir;
	wire wr_out = wr_en_in && hit_out;

	// the memory pins only leave their defaults once the mode is known
	wire boot_ready = (boot_state == BOOT_READY);
	wire strobe_live = boot_ready && strobe_release;
	wire cs_live = boot_ready && cs_release;

	sync_two_ff mode_sync_ff (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.async_in(boot_area_size_mode_in),
		.sync_out(mode_sync)
	);

	assign i2c_pullup_en[IDX_B_DATA] = pullup_ctrl_three[BIT_I2C_B_DATA];
	assign i2c_pullup_en[IDX_B_CLOCK] = pullup_ctrl_three[BIT_I2C_B_CLOCK];
	assign i2c_pullup_en[IDX_A_DATA] = pullup_ctrl_three[BIT_I2C_A_DATA];
	assign i2c_pullup_en[IDX_A_CLOCK] = pullup_ctrl_three[BIT_I2C_A_CLOCK];
	assign i2c_pullup_en[IDX_C_DATA] = pullup_ctrl_four[BIT_I2C_C_DATA];
	assign i2c_pullup_en[IDX_C_CLOCK] = pullup_ctrl_four[BIT_I2C_C_CLOCK];

	// all function and port bits reset to zero, so every pad starts as an input
	// pins leave reset as port inputs
	genvar gi;
	generate
		for (gi = 0; gi < NUM_I2C_PINS; gi++)
		begin : g_i2c_pad
			i2c_pad_cell pad (
				.ref_clk_in(ref_clk_in),
				.sys_rst_in(sys_rst_in),
				.pad_in(i2c_pad_in[gi]),
				.i2c_func_sel_in(func_sel[gi]),
				.gpio_dir_in(gpio_dir[gi]),
				.gpio_level_in(gpio_out[gi]),
				.i2c_drive_low_in(i2c_drive_low_in[gi]),
				.pullup_en_in(i2c_pullup_en[gi]),
				.pad_out(i2c_pad_out[gi]),
				.pad_oe_out(i2c_pad_oe_out[gi]),
				.pullup_out(i2c_pullup_out[gi]),
				.level_out(i2c_level_out[gi])
			);
		end
	endgenerate

	// boot sequence: let the strap synchroniser fill, then capture once
	// the latched mode then holds until the next reset, so a strap that
	// moves later cannot flip the area size under a running boot
	always_comb
	begin
		next_boot_state = boot_state;
		case (boot_state)
			BOOT_SETTLE:
			begin
				if (settle_count == SETTLE_CYCLES)
					next_boot_state = BOOT_CAPTURE;
			end
			BOOT_CAPTURE:
				next_boot_state = BOOT_READY;
			BOOT_READY:
				next_boot_state = BOOT_READY;
			default:
				next_boot_state = BOOT_SETTLE;
		endcase
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			boot_state <= BOOT_SETTLE;
			settle_count <= 2'd0;
			boot_mode <= 1'b0;
		end
		else
		begin
			boot_state <= next_boot_state;
			if (boot_state == BOOT_SETTLE)
				settle_count <= settle_count + 2'd1;
			// strap is caught after release, never by the reset itself
			if (boot_state == BOOT_CAPTURE)
				boot_mode <= mode_sync;
		end
	end

	assign boot_area_size_mode_out = boot_mode;

	// every bit is stored and read back, including those whose pins sit
	// elsewhere, so software sees exactly the word it wrote
	// pull-up registers reset to ones
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			pullup_ctrl_three <= PULLUP_THREE_RST;
			pullup_ctrl_four <= PULLUP_FOUR_RST;
		end
		else
		begin
			if (wr_three)
				pullup_ctrl_three <= wr_data_in;
			if (wr_four)
				pullup_ctrl_four <= wr_data_in;
		end
	end

	assign pullup_ctrl_three_out = pullup_ctrl_three;
	assign pullup_ctrl_four_out = pullup_ctrl_four;

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			func_sel <= FUNC_SEL_RST;
			gpio_dir <= GPIO_DIR_RST;
			gpio_out <= GPIO_OUT_RST;
			strobe_release <= 1'b0;
			cs_release <= 1'b0;
		end
		else
		begin
			if (wr_func)
			begin
				func_sel <= wr_data_in[FUNC_SEL_LSB +: NUM_I2C_PINS];
				strobe_release <= wr_data_in[STROBE_REL_BIT];
				cs_release <= wr_data_in[CS_REL_BIT];
			end
			if (wr_dir)
				gpio_dir <= wr_data_in[NUM_I2C_PINS-1:0];
			if (wr_out)
				gpio_out <= wr_data_in[NUM_I2C_PINS-1:0];
		end
	end

	// memory strobe pairs: defaults until software hands them over
	// clearing the release bit returns both pins of every pair to the keepers
	genvar si;
	generate
		for (si = 0; si < NUM_STROBE_PAIRS; si++)
		begin : g_strobe
			always_ff @(posedge ref_clk_in)
			begin
				if (sys_rst_in || !strobe_live)
				begin
					mem_strobe_true_oe_out[si] <= 1'b0;
					mem_strobe_comp_oe_out[si] <= 1'b0;
					mem_strobe_true_out[si] <= 1'b0;
					mem_strobe_comp_out[si] <= 1'b1;
					mem_strobe_true_hold_low_out[si] <= 1'b1;
					mem_strobe_comp_hold_high_out[si] <= 1'b1;
				end
				else
				begin
					mem_strobe_true_oe_out[si] <= mem_strobe_oe_in[si];
					mem_strobe_comp_oe_out[si] <= mem_strobe_oe_in[si];
					mem_strobe_true_out[si] <= mem_strobe_level_in[si];
					mem_strobe_comp_out[si] <= ~mem_strobe_level_in[si];
					// keepers only while nothing drives, to avoid fighting the driver
					mem_strobe_true_hold_low_out[si] <= ~mem_strobe_oe_in[si];
					mem_strobe_comp_hold_high_out[si] <= ~mem_strobe_oe_in[si];
				end
			end
		end
	endgenerate

	// the shared pin floats until the strap is caught: a few cycles of float
	// are safer than briefly showing the wrong area size to the memory
	// shared chip-select/address pin
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			chip_select_addr_shared_out <= 1'b0;
			chip_select_addr_shared_oe_out <= 1'b0;
		end
		else if (cs_live)
		begin
			chip_select_addr_shared_out <= mem_cs_addr_level_in;
			chip_select_addr_shared_oe_out <= 1'b1;
		end
		else if (boot_ready)
		begin
			chip_select_addr_shared_out <= ~boot_mode;
			chip_select_addr_shared_oe_out <= 1'b1;
		end
		else
		begin
			chip_select_addr_shared_out <= 1'b0;
			chip_select_addr_shared_oe_out <= 1'b0;
		end
	end

	// read mux; unmapped addresses read as zero
	// status bit 9 reports the strobe defaults from the release bit alone
	wire [DATA_W-1:0] func_word = {14'h0000, cs_release, strobe_release,
		10'h000, func_sel};
	wire [DATA_W-1:0] status_word = {22'h00_0000, ~strobe_release, boot_mode,
		2'h0, i2c_level_out};
	wire [DATA_W-1:0] next_rd_data =
		hit_three ? pullup_ctrl_three :
		hit_four ? pullup_ctrl_four :
		hit_func ? func_word :
		hit_dir ? {26'h000_0000, gpio_dir} :
		hit_out ? {26'h000_0000, gpio_out} :
		hit_status ? status_word : 32'h0000_0000;

	// data stand for one cycle only
	// returning zero between reads keeps stale words off the bus
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
			rd_data_out <= 32'h0000_0000;
		else if (rd_en_in)
			rd_data_out <= next_rd_data;
		else
			rd_data_out <= 32'h0000_0000;
	end
endmodule : pin_default_pullup_ctrl

// *** core/sync_two_ff.sv ***
// two flip-flop synchroniser for one level from a pin
// assumes the input is asynchronous to ref_clk_in
`timescale 1ns/1ps
module sync_two_ff (
	input wire logic ref_clk_in, // system clock
	input wire logic sys_rst_in, // synchronous reset, active high
	input wire logic async_in, // level from outside the domain
	output logic sync_out // level safe for logic
);
	logic stage_one;

	// first stage feeds only the second stage
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			stage_one <= 1'b0;
			sync_out <= 1'b0;
		end
		else
		begin
			stage_one <= async_in;
			sync_out <= stage_one;
		end
	end
endmodule : sync_two_ff

// *** tb/pin_default_pullup_ctrl_assertions.sv ***
// port-level checker for the pin default and pull-up controller
// assumes one clock domain; bound onto the top module below
`timescale 1ns/1ps
module pin_default_pullup_ctrl_checker
	import pin_ctrl_pkg::*;
(
	input wire logic ref_clk_in, // clock
	input wire logic sys_rst_in, // reset
	input wire logic [pin_ctrl_pkg::ADDR_W-1:0] addr_in, // address
	input wire logic [pin_ctrl_pkg::DATA_W-1:0] wr_data_in, // write data
	input wire logic wr_en_in, // write strobe
	input wire logic rd_en_in, // read strobe
	input wire logic [pin_ctrl_pkg::DATA_W-1:0] rd_data_out, // read data
	input wire logic [pin_ctrl_pkg::NUM_I2C_PINS-1:0] i2c_pad_oe_out, // enables
	input wire logic [pin_ctrl_pkg::NUM_I2C_PINS-1:0] i2c_pullup_out, // pull-ups
	input wire logic [pin_ctrl_pkg::DATA_W-1:0] pullup_ctrl_three_out, // reg 3
	input wire logic [pin_ctrl_pkg::DATA_W-1:0] pullup_ctrl_four_out, // reg 4
	input wire logic [pin_ctrl_pkg::NUM_STROBE_PAIRS-1:0] mem_strobe_true_out, // level
	input wire logic [pin_ctrl_pkg::NUM_STROBE_PAIRS-1:0] mem_strobe_true_oe_out, // oe
	input wire logic [pin_ctrl_pkg::NUM_STROBE_PAIRS-1:0] mem_strobe_true_hold_low_out, // keep
	input wire logic [pin_ctrl_pkg::NUM_STROBE_PAIRS-1:0] mem_strobe_comp_out, // level
	input wire logic [pin_ctrl_pkg::NUM_STROBE_PAIRS-1:0] mem_strobe_comp_oe_out, // oe
	input wire logic [pin_ctrl_pkg::NUM_STROBE_PAIRS-1:0] mem_strobe_comp_hold_high_out, // keep
	input wire logic chip_select_addr_shared_out, // shared pin
	input wire logic chip_select_addr_shared_oe_out, // shared enable
	input wire logic boot_area_size_mode_out // latched mode
);
	default clocking cb @(posedge ref_clk_in);
	endclocking
	sequence s_wr3;
		wr_en_in && addr_in == OFS_PULLUP_THREE;
	endsequence
	sequence s_wr4;
		wr_en_in && addr_in == OFS_PULLUP_FOUR;
	endsequence
	// reset checks carry no disable: they watch the reset itself
	a_rst_strobe_hiz: assert property (sys_rst_in |=> (mem_strobe_true_oe_out |
		mem_strobe_comp_oe_out) == 4'h0 && mem_strobe_true_hold_low_out == 4'hf)
		else $error("strobe driver active in reset");
	a_rst_i2c_input: assert property (sys_rst_in |=> i2c_pad_oe_out == 6'h00 &&
		i2c_pullup_out == 6'h3f && (pullup_ctrl_three_out & pullup_ctrl_four_out) == '1)
		else $error("i2c pin or pull-up wrong in reset");
	a_keeper_true: assert property (disable iff (sys_rst_in)
		(~mem_strobe_true_oe_out & ~mem_strobe_true_hold_low_out) == 4'h0)
		else $error("true strobe floats without keeper");
	a_keeper_comp: assert property (disable iff (sys_rst_in)
		(~mem_strobe_comp_oe_out & ~mem_strobe_comp_hold_high_out) == 4'h0)
		else $error("comp strobe floats without keeper");
	a_strobe_pair_match: assert property (disable iff (sys_rst_in)
		mem_strobe_comp_out == ~mem_strobe_true_out &&
		mem_strobe_comp_oe_out == mem_strobe_true_oe_out)
		else $error("strobe pair out of step");
	a_write_three: assert property (disable iff (sys_rst_in) s_wr3 |=>
		pullup_ctrl_three_out == $past(wr_data_in) ##1
		i2c_pullup_out[3:0] == $past(wr_data_in[31:28], 2))
		else $error("reg 3 write not applied");
	a_write_four: assert property (disable iff (sys_rst_in) s_wr4 |=>
		pullup_ctrl_four_out == $past(wr_data_in) ##1
		i2c_pullup_out[5:4] == $past(wr_data_in[21:20], 2))
		else $error("reg 4 write not applied");
	a_read_three: assert property (disable iff (sys_rst_in)
		rd_en_in && addr_in == OFS_PULLUP_THREE |=> rd_data_out == $past(pullup_ctrl_three_out))
		else $error("reg 3 read mismatch");
	a_read_four: assert property (disable iff (sys_rst_in)
		rd_en_in && addr_in == OFS_PULLUP_FOUR |=> rd_data_out == $past(pullup_ctrl_four_out))
		else $error("reg 4 read mismatch");
	a_shared_default: assert property (disable iff (sys_rst_in)
		$rose(chip_select_addr_shared_oe_out) |->
		chip_select_addr_shared_out == !boot_area_size_mode_out)
		else $error("shared pin default wrong");
	a_shared_timely: assert property (disable iff (sys_rst_in)
		$fell(sys_rst_in) |-> ##[1:8] chip_select_addr_shared_oe_out)
		else $error("shared pin never driven");
endmodule : pin_default_pullup_ctrl_checker

bind pin_default_pullup_ctrl pin_default_pullup_ctrl_checker checker_inst (.*);

// *** tb/test_pin_default_pullup_ctrl.sv ***
// self-checking bench for the pin default and pull-up controller
// assumes design files and checker are compiled ahead of it
`timescale 1ns/1ps
module test_pin_default_pullup_ctrl;
	import pin_ctrl_pkg::*;
	logic ref_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [ADDR_W-1:0] addr_in = 8'h00;
	logic [DATA_W-1:0] wr_data_in = 32'h0;
	logic wr_en_in = 1'b0;
	logic rd_en_in = 1'b0;
	logic boot_mode = 1'b0;
	wire logic [DATA_W-1:0] rd_data_out, three, four;
	wire logic [NUM_I2C_PINS-1:0] pad_oe, pull, pad_out, lvl;
	wire logic [NUM_STROBE_PAIRS-1:0] t_out, t_oe, t_hold, c_out, c_oe, c_hold;
	wire logic cs_out, cs_oe, mode_out;
	int num_errors = 0;
	int check_count = 0;
	logic [DATA_W-1:0] r3 [8] = '{32'h0, 32'h1000_0001, 32'h2000_0000, 32'h4000_0000,
		32'h8000_0000, 32'h0, 32'h0, 32'hefff_ffff};
	logic [DATA_W-1:0] r4 [8] = '{32'h0, 32'h0, 32'h8000_0001, 32'h0,
		32'h0, 32'h0010_0000, 32'h0020_0000, 32'hffdf_ffff};
	logic [5:0] exp_pull [8] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h1e};

	// controller strobe inputs stay active: they must be ignored by default
	pin_default_pullup_ctrl DUT (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in),
		.rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
		.boot_area_size_mode_in(boot_mode), .i2c_pad_in(6'h2a), .i2c_drive_low_in(6'h3f),
		.i2c_pad_out(pad_out), .i2c_pad_oe_out(pad_oe),
		.i2c_pullup_out(pull), .i2c_level_out(lvl),
		.pullup_ctrl_three_out(three), .pullup_ctrl_four_out(four),
		.mem_strobe_oe_in(4'hf), .mem_strobe_level_in(4'hf),
		.mem_strobe_true_out(t_out), .mem_strobe_true_oe_out(t_oe),
		.mem_strobe_true_hold_low_out(t_hold), .mem_strobe_comp_out(c_out),
		.mem_strobe_comp_oe_out(c_oe), .mem_strobe_comp_hold_high_out(c_hold),
		.mem_cs_addr_level_in(1'b0), .chip_select_addr_shared_out(cs_out),
		.chip_select_addr_shared_oe_out(cs_oe), .boot_area_size_mode_out(mode_out));

	always #2.5 ref_clk_in = ~ref_clk_in;

	task summarize;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize

	task chk(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
		check_count++;
		if (g !== e)
		begin
			$display("unexpected %s expected %h seen %h", n, e, g);
			num_errors++;
		end
	endtask : chk

	task cyc(input logic w, input logic r, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		@(posedge ref_clk_in);
		wr_en_in <= w;
		rd_en_in <= r;
		addr_in <= a;
		wr_data_in <= d;
	endtask : cyc

	task idle(input int n);
		repeat (n) cyc(1'b0, 1'b0, 8'h00, 32'h0);
		#1;
	endtask : idle

	// the read data are looked at in the one cycle they stand
	task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string n);
		cyc(1'b0, 1'b1, a, 32'h0);
		idle(1);
		chk(n, e, rd_data_out);
	endtask : rd

	task pins_default;
		chk("i2c_oe", 32'h0, pad_oe);
		chk("i2c_pull", 32'h3f, pull);
		chk("strobe_oe", 32'h0, {t_oe, c_oe});
		chk("strobe_lvl", 32'h0f, {t_out, c_out});
		chk("keepers", 32'hff, {t_hold, c_hold});
	endtask : pins_default

	task do_reset(input logic m);
		@(posedge ref_clk_in);
		sys_rst_in <= 1'b1;
		boot_mode <= m;
		repeat (6) @(posedge ref_clk_in);
		#1;
		pins_default();
		chk("reg3", 32'hffff_ffff, three);
		chk("reg4", 32'hffff_ffff, four);
		chk("cs_oe_rst", 32'h0, cs_oe);
		repeat (5) @(posedge ref_clk_in);
		sys_rst_in <= 1'b0;
	endtask : do_reset

	task post_boot(input logic m);
		idle(10);
		chk("cs_oe", 32'h1, cs_oe);
		chk("cs_out", {31'h0, !m}, cs_out);
		chk("mode_out", {31'h0, m}, mode_out);
		pins_default();
		chk("i2c_out", 32'h0, pad_out);
		chk("i2c_lvl", 32'h2a, lvl);
		rd(OFS_PULLUP_THREE, 32'hffff_ffff, "rd3_rst");
		rd(OFS_PULLUP_FOUR, 32'hffff_ffff, "rd4_rst");
		rd(OFS_PIN_STATUS, {22'h0, 1'b1, m, 8'h2a}, "rd_status");
	endtask : post_boot

	initial
	begin
		do_reset(1'b0);
		post_boot(1'b0);
		$display("test reset_defaults done");
		for (int i = 0; i < 8; i++)
		begin
			cyc(1'b1, 1'b0, OFS_PULLUP_THREE, r3[i]);
			cyc(1'b1, 1'b0, OFS_PULLUP_FOUR, r4[i]);
			idle(3);
			chk("reg3", r3[i], three);
			chk("reg4", r4[i], four);
			chk("pull", {26'h0, exp_pull[i]}, pull);
			rd(OFS_PULLUP_THREE, r3[i], "rd3");
			rd(OFS_PULLUP_FOUR, r4[i], "rd4");
		end
		$display("test pullup_rows done");
		cyc(1'b1, 1'b0, OFS_PULLUP_FOUR, 32'h8000_0001);
		rd(OFS_PULLUP_FOUR, 32'h8000_0001, "rd4_b2b");
		cyc(1'b1, 1'b0, 8'hfc, 32'h0);
		rd(8'hfc, 32'h0, "unmapped");
		rd(OFS_PULLUP_FOUR, 32'h8000_0001, "rd4_kept");
		$display("test back_to_back done");
		// hand the pins over, then take them back as port outputs
		cyc(1'b1, 1'b0, OFS_PIN_FUNC, 32'h0003_003f);
		cyc(1'b1, 1'b0, OFS_PIN_STATUS, 32'hffff_ffff);
		idle(3);
		chk("i2c_oe_fn", 32'h3f, pad_oe);
		chk("i2c_out_fn", 32'h0, pad_out);
		chk("strobe_oe_rel", 32'hff, {t_oe, c_oe});
		chk("strobe_lvl_rel", 32'hf0, {t_out, c_out});
		chk("keepers_rel", 32'h0, {t_hold, c_hold});
		chk("cs_rel", 32'h2, {cs_oe, cs_out});
		rd(OFS_PIN_FUNC, 32'h0003_003f, "rd_func");
		rd(OFS_PIN_STATUS, 32'h0000_002a, "rd_status_rel");
		cyc(1'b1, 1'b0, OFS_PIN_FUNC, 32'h0);
		cyc(1'b1, 1'b0, OFS_GPIO_DIR, 32'h3f);
		cyc(1'b1, 1'b0, OFS_GPIO_OUT, 32'h15);
		idle(3);
		chk("port_oe", 32'h3f, pad_oe);
		chk("port_out", 32'h15, pad_out);
		chk("strobe_oe_back", 32'h0, {t_oe, c_oe});
		chk("cs_back", 32'h3, {cs_oe, cs_out});
		rd(OFS_GPIO_DIR, 32'h3f, "rd_dir");
		rd(OFS_GPIO_OUT, 32'h15, "rd_out");
		$display("test pin_handover done");
		do_reset(1'b1);
		post_boot(1'b1);
		$display("test boot_mode_one done");
		summarize();
	end

	// about 155 cycles are needed; 4000 leaves ample margin
	initial
	begin
		#20000;
		num_errors++;
		summarize();
	end
endmodule : test_pin_default_pullup_ctrl
